// ### ppac_core.sv
// What this block does
// R1 - Drive bus on selected read, else release
// R2 - Access only with select_high and select_low_n
// R3 - Four-bit index picks one of sixteen registers
// R4 - Index 15 mirrors port A without handshake
// R5 - Open-drain interrupt when enabled flag set
// R6 - Direction bit zero input, one output
// R7 - Output pin follows its output latch bit
// R8 - Latch writes kept while pin is input
// R9 - Port reads return input view, live when unlatched
// R10 - Latched port A holds pins at edge
// R11 - Reading latched port A pops one word; transparency returns once the queue empties
// R12 - Port B outputs read latch, A reads pins
// R13 - Port B inputs read captured or live level
// R14 - aux_control enables latching per port
// R15 - Port A control lines set own flags
// R16 - Port B control lines set own flags
// R17 - Timer drives timer_pin, count_pin feeds counter
// R18 - Port A read handshake supported here
// R19 - Data-ready sets flag, a_ctl_io answers taken
// R20 - Data-taken as pulse or level form
// R21 - Peripheral sends data then data-ready, repeats
// R22 - Clear resets registers except timers, shifter
// R23 - Read_not_write low writes, high reads
// R24 - Interrupt released once no enabled flag remains
// R25 - Pulse form lows one cycle after read
module ppac_core #(
    parameter int FIFO_DEPTH = ppac_pkg::FIFO_DEPTH
)
(
    // System
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic chip_clear_n,
    // Host bus
    input wire logic select_high,
    input wire logic select_low_n,
    input wire logic read_not_write,
    input wire logic [3:0] reg_index,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    // Interrupt request, open drain
    output logic intr_req_out,
    output logic intr_req_oe,
    // Port A
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe,
    output logic a_latch_room,
    // Port A control lines
    input wire logic a_ctl_in,
    input wire logic a_ctl_io_in,
    output logic a_ctl_io_out,
    output logic a_ctl_io_oe,
    // Port B
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    // Port B control lines
    input wire logic b_ctl_one_in,
    output logic b_ctl_one_out,
    output logic b_ctl_one_oe,
    input wire logic b_ctl_two_in,
    output logic b_ctl_two_out,
    output logic b_ctl_two_oe,
    // Timer hooks
    input wire logic timer1_wave,
    output logic count_pulse
);

    ppac_pkg::ppac_req_t req;
    logic clear_all;
    logic rd_take;
    logic wr_take;
    logic is_a_hs;
    logic is_a_quiet;
    logic is_b;
    logic [7:0] out_latch_b_reg;
    logic [7:0] out_latch_a_reg;
    logic [7:0] dir_b_reg;
    logic [7:0] dir_a_reg;
    logic [7:0] aux_control_reg;
    logic [7:0] periph_control_reg;
    logic [6:0] intr_enables_reg;
    logic [6:0] intr_flags_reg;
    logic [6:0] intr_flags_next;
    logic [6:0] flag_set;
    logic [6:0] flag_clr;
    logic [7:0] timer_store_reg [4:10];
    logic a_in_prev_reg;
    logic a_io_prev_reg;
    logic b_one_prev_reg;
    logic b_two_prev_reg;
    logic count_prev_reg;
    logic [7:0] b_capture_reg;
    logic [7:0] host_data_out_reg;
    logic host_data_oe_reg;
    logic intr_req_oe_reg;
    logic intr_req_out_reg;
    logic [7:0] port_b_out_reg;
    logic a_ctl_io_out_reg;
    logic a_ctl_io_oe_reg;
    logic b_ctl_two_out_reg;
    logic b_ctl_two_oe_reg;
    logic count_pulse_reg;
    logic a_latch_room_reg;
    ppac_pkg::ppac_hs_t hs_reg;
    ppac_pkg::ppac_hs_t hs_next;
    logic [2:0] a_io_mode;
    logic [2:0] b_two_mode;
    logic a_in_edge;
    logic a_io_edge;
    logic b_one_edge;
    logic b_two_edge;
    logic latch_a_en;
    logic latch_b_en;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_pop;
    logic [7:0] in_view_a;
    logic [7:0] in_view_b;
    logic [7:0] port_b_read;
    logic [7:0] rd_mux;
    logic [7:0] port_b_drive;
    logic irq_next;
    logic a_io_drive_next;

    // Both resets are sampled on the clock; chip_clear_n spares the timer and shifter slots
    assign clear_all = !rst_n || !chip_clear_n; // [R22]

    assign req = '{sel: select_high && !select_low_n, rnw: read_not_write,
                   idx: reg_index, wdata: host_data_in}; // [R2]
    assign rd_take = req.sel && req.rnw; // [R23]
    assign wr_take = req.sel && !req.rnw; // [R23]
    assign is_a_hs = (req.idx == ppac_pkg::REG_PORT_A_DATA);
    assign is_a_quiet = (req.idx == ppac_pkg::REG_PORT_A_DATA_QUIET);
    assign is_b = (req.idx == ppac_pkg::REG_PORT_B_DATA);

    // Control line edges and modes
    assign a_io_mode = periph_control_reg[ppac_pkg::PCR_A_IO_MODE +: 3];
    assign b_two_mode = periph_control_reg[ppac_pkg::PCR_B_TWO_MODE +: 3];
    assign a_in_edge = periph_control_reg[ppac_pkg::PCR_A_IN_RISE] ? (a_ctl_in && !a_in_prev_reg)
                                                                   : (!a_ctl_in && a_in_prev_reg); // [R15] [R19]
    assign a_io_edge = !a_io_mode[ppac_pkg::MODE_OUT_BIT]
                       && (a_io_mode[ppac_pkg::MODE_RISE_BIT] ? (a_ctl_io_in && !a_io_prev_reg)
                                                              : (!a_ctl_io_in && a_io_prev_reg)); // [R15]
    assign b_one_edge = periph_control_reg[ppac_pkg::PCR_B_ONE_RISE] ? (b_ctl_one_in && !b_one_prev_reg)
                                                                     : (!b_ctl_one_in && b_one_prev_reg); // [R16]
    assign b_two_edge = !b_two_mode[ppac_pkg::MODE_OUT_BIT]
                        && (b_two_mode[ppac_pkg::MODE_RISE_BIT] ? (b_ctl_two_in && !b_two_prev_reg)
                                                                : (!b_ctl_two_in && b_two_prev_reg)); // [R16]

    assign latch_a_en = aux_control_reg[ppac_pkg::AUX_LATCH_A]; // [R14]
    assign latch_b_en = aux_control_reg[ppac_pkg::AUX_LATCH_B]; // [R14]

    // Captured port A words queue up; a full queue refuses further captures
    ppac_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    )
    u_latch_fifo (
        .clk(ref_clk),
        .clear(clear_all || !latch_a_en),
        .in_valid(a_in_edge && latch_a_en), // [R10]
        .in_ready(fifo_in_ready),
        .in_data(port_a_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // Any read of port A consumes the latched word, quiet index included
    assign fifo_pop = rd_take && (is_a_hs || is_a_quiet); // [R11] [R4]
    // Outputs on port A read back the pin itself, so loading shows through
    assign in_view_a = (latch_a_en && fifo_out_valid) ? fifo_out_data : port_a_in; // [R9] [R10] [R12]
    assign in_view_b = latch_b_en ? b_capture_reg : port_b_in; // [R13]
    assign port_b_read = (dir_b_reg & out_latch_b_reg) | (~dir_b_reg & in_view_b); // [R12]

    // Read selection
    assign rd_mux = is_b ? port_b_read
                  : (is_a_hs || is_a_quiet) ? in_view_a // [R4]
                  : (req.idx == ppac_pkg::REG_PORT_B_DIRECTION) ? dir_b_reg
                  : (req.idx == ppac_pkg::REG_PORT_A_DIRECTION) ? dir_a_reg
                  : (req.idx == ppac_pkg::REG_AUX_CONTROL) ? aux_control_reg
                  : (req.idx == ppac_pkg::REG_PERIPH_CONTROL) ? periph_control_reg
                  : (req.idx == ppac_pkg::REG_INTR_FLAGS) ? {irq_next, intr_flags_reg}
                  : (req.idx == ppac_pkg::REG_INTR_ENABLES) ? {1'b1, intr_enables_reg}
                  : timer_store_reg[req.idx]; // [R3]

    // Flags: hardware set wins over any clear in the same cycle
    assign flag_set = (7'(a_io_edge) << ppac_pkg::FLAG_A_IO) | (7'(a_in_edge) << ppac_pkg::FLAG_A_IN) // [R15] [R19]
                      | (7'(b_two_edge) << ppac_pkg::FLAG_B_TWO) | (7'(b_one_edge) << ppac_pkg::FLAG_B_ONE); // [R16]
    assign flag_clr = ((wr_take && req.idx == ppac_pkg::REG_INTR_FLAGS) ? req.wdata[6:0] : 7'h00)
                      | ((req.sel && is_a_hs) ? 7'((1 << ppac_pkg::FLAG_A_IO) | (1 << ppac_pkg::FLAG_A_IN)) : 7'h00)
                      | ((req.sel && is_b) ? 7'((1 << ppac_pkg::FLAG_B_TWO) | (1 << ppac_pkg::FLAG_B_ONE)) : 7'h00);
    assign intr_flags_next = (intr_flags_reg & ~flag_clr) | flag_set;
    assign irq_next = |(intr_flags_next & intr_enables_reg); // [R5] [R24]

    // Timer output takes bit 7 only when both direction and aux_control agree
    assign port_b_drive = {(dir_b_reg[7] && aux_control_reg[ppac_pkg::AUX_TIMER_PIN]) ? timer1_wave
                                                                                      : out_latch_b_reg[7],
                           out_latch_b_reg[6:0]}; // [R17] [R7]

    // Read handshake on a_ctl_io
    always_comb
    begin
        hs_next = hs_reg;
        case (hs_reg)
            ppac_pkg::HS_HIGH:
            begin
                if (rd_take && is_a_hs)
                begin
                    hs_next = (a_io_mode == ppac_pkg::MODE_PULSE) ? ppac_pkg::HS_PULSE : ppac_pkg::HS_LOW; // [R20] [R25]
                end
            end
            ppac_pkg::HS_LOW:
            begin
                if (a_in_edge || a_io_mode == ppac_pkg::MODE_PULSE)
                begin
                    hs_next = ppac_pkg::HS_HIGH; // [R20]
                end
            end
            ppac_pkg::HS_PULSE:
            begin
                hs_next = ppac_pkg::HS_HIGH; // [R25]
            end
            default:
            begin
                hs_next = ppac_pkg::HS_HIGH;
            end
        endcase
        if (a_io_mode != ppac_pkg::MODE_HANDSHAKE && a_io_mode != ppac_pkg::MODE_PULSE)
        begin
            hs_next = ppac_pkg::HS_HIGH;
        end
    end

    assign a_io_drive_next = (a_io_mode == ppac_pkg::MODE_DRIVE_LOW) ? 1'b0
                           : (a_io_mode == ppac_pkg::MODE_DRIVE_HIGH) ? 1'b1
                           : (hs_next == ppac_pkg::HS_HIGH); // [R19]

    // Host-writable registers
    always_ff @(posedge ref_clk)
    begin
        if (clear_all)
        begin
            out_latch_b_reg <= ppac_pkg::REG_RESET;
            out_latch_a_reg <= ppac_pkg::REG_RESET;
            dir_b_reg <= ppac_pkg::REG_RESET;
            dir_a_reg <= ppac_pkg::REG_RESET; // [R22]
            aux_control_reg <= ppac_pkg::REG_RESET;
            periph_control_reg <= ppac_pkg::REG_RESET;
        end
        else if (wr_take)
        begin
            if (is_b)
            begin
                out_latch_b_reg <= req.wdata; // [R8]
            end
            else if (is_a_hs || is_a_quiet)
            begin
                out_latch_a_reg <= req.wdata; // [R8] [R4]
            end
            else if (req.idx == ppac_pkg::REG_PORT_B_DIRECTION)
            begin
                dir_b_reg <= req.wdata;
            end
            else if (req.idx == ppac_pkg::REG_PORT_A_DIRECTION)
            begin
                dir_a_reg <= req.wdata;
            end
            else if (req.idx == ppac_pkg::REG_AUX_CONTROL)
            begin
                aux_control_reg <= req.wdata; // [R14]
            end
            else if (req.idx == ppac_pkg::REG_PERIPH_CONTROL)
            begin
                periph_control_reg <= req.wdata;
            end
        end
    end

    // Timer and shifter slots survive chip_clear_n
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 4; i <= 10; i++)
            begin
                timer_store_reg[i] <= ppac_pkg::REG_RESET;
            end
        end
        else if (wr_take && req.idx >= ppac_pkg::REG_TIMER1_COUNT_LOW
                 && req.idx <= ppac_pkg::REG_SERIAL_SHIFT)
        begin
            timer_store_reg[req.idx] <= req.wdata; // [R22]
        end
    end

    // Interrupt flags and enables
    always_ff @(posedge ref_clk)
    begin
        if (clear_all)
        begin
            intr_flags_reg <= 7'h00;
            intr_enables_reg <= 7'h00; // [R22]
            intr_req_oe_reg <= 1'b0;
        end
        else
        begin
            intr_flags_reg <= intr_flags_next;
            intr_req_oe_reg <= irq_next; // [R5] [R24]
            if (wr_take && req.idx == ppac_pkg::REG_INTR_ENABLES)
            begin
                intr_enables_reg <= req.wdata[ppac_pkg::IER_SET] ? (intr_enables_reg | req.wdata[6:0])
                                                                  : (intr_enables_reg & ~req.wdata[6:0]);
            end
        end
    end

    // Edge history and port B capture
    always_ff @(posedge ref_clk)
    begin
        if (clear_all)
        begin
            a_in_prev_reg <= 1'b0;
            a_io_prev_reg <= 1'b0;
            b_one_prev_reg <= 1'b0;
            b_two_prev_reg <= 1'b0;
            count_prev_reg <= 1'b0;
            b_capture_reg <= ppac_pkg::REG_RESET;
        end
        else
        begin
            a_in_prev_reg <= a_ctl_in;
            a_io_prev_reg <= a_ctl_io_in;
            b_one_prev_reg <= b_ctl_one_in;
            b_two_prev_reg <= b_ctl_two_in;
            count_prev_reg <= port_b_in[ppac_pkg::COUNT_PIN];
            if (b_one_edge)
            begin
                b_capture_reg <= port_b_in; // [R13]
            end
        end
    end

    // Host bus answer, one cycle after the access is taken
    always_ff @(posedge ref_clk)
    begin
        if (clear_all)
        begin
            host_data_out_reg <= ppac_pkg::REG_RESET;
            host_data_oe_reg <= 1'b0;
        end
        else
        begin
            host_data_oe_reg <= rd_take; // [R1]
            host_data_out_reg <= rd_take ? rd_mux : host_data_out_reg; // [R1]
        end
    end

    // Pin drivers
    always_ff @(posedge ref_clk)
    begin
        if (clear_all)
        begin
            hs_reg <= ppac_pkg::HS_HIGH;
            a_ctl_io_out_reg <= 1'b1;
            a_ctl_io_oe_reg <= 1'b0;
            b_ctl_two_out_reg <= 1'b1;
            b_ctl_two_oe_reg <= 1'b0;
            port_b_out_reg <= ppac_pkg::REG_RESET;
            count_pulse_reg <= 1'b0;
            intr_req_out_reg <= 1'b0;
            a_latch_room_reg <= 1'b0;
        end
        else
        begin
            hs_reg <= hs_next; // [R18]
            a_ctl_io_out_reg <= a_io_drive_next; // [R20]
            a_ctl_io_oe_reg <= a_io_mode[ppac_pkg::MODE_OUT_BIT]; // [R15]
            b_ctl_two_out_reg <= (b_two_mode != ppac_pkg::MODE_DRIVE_LOW); // [R16]
            b_ctl_two_oe_reg <= b_two_mode[ppac_pkg::MODE_OUT_BIT];
            port_b_out_reg <= port_b_drive; // [R7]
            count_pulse_reg <= count_prev_reg && !port_b_in[ppac_pkg::COUNT_PIN]; // [R17]
            intr_req_out_reg <= 1'b0; // [R5]
            a_latch_room_reg <= fifo_in_ready && latch_a_en; // [R21]
        end
    end

    assign host_data_out = host_data_out_reg;
    assign host_data_oe = host_data_oe_reg;
    assign intr_req_out = intr_req_out_reg;
    assign intr_req_oe = intr_req_oe_reg;
    // Input pins stay high impedance; stored latch bits reach the pin once direction flips
    assign port_a_out = out_latch_a_reg; // [R7] [R8]
    assign port_a_oe = dir_a_reg; // [R6]
    assign port_b_out = port_b_out_reg;
    assign port_b_oe = dir_b_reg; // [R6]
    assign a_ctl_io_out = a_ctl_io_out_reg;
    assign a_ctl_io_oe = a_ctl_io_oe_reg;
    // Shifter clocking is outside this block, so b_ctl_one is never driven here
    assign b_ctl_one_out = 1'b0;
    assign b_ctl_one_oe = 1'b0;
    assign b_ctl_two_out = b_ctl_two_out_reg;
    assign b_ctl_two_oe = b_ctl_two_oe_reg;
    assign count_pulse = count_pulse_reg;
    assign a_latch_room = a_latch_room_reg;

endmodule

// ### ppac_pkg.sv
package ppac_pkg;

    localparam int DATA_W = 8;
    localparam int IDX_W = 4;
    localparam int FIFO_DEPTH = 8;

    // Register indices
    localparam logic [3:0] REG_PORT_B_DATA = 4'h0;
    localparam logic [3:0] REG_PORT_A_DATA = 4'h1;
    localparam logic [3:0] REG_PORT_B_DIRECTION = 4'h2;
    localparam logic [3:0] REG_PORT_A_DIRECTION = 4'h3;
    localparam logic [3:0] REG_TIMER1_COUNT_LOW = 4'h4;
    localparam logic [3:0] REG_TIMER1_COUNT_HIGH = 4'h5;
    localparam logic [3:0] REG_TIMER1_LATCH_LOW = 4'h6;
    localparam logic [3:0] REG_TIMER1_LATCH_HIGH = 4'h7;
    localparam logic [3:0] REG_TIMER2_COUNT_LOW = 4'h8;
    localparam logic [3:0] REG_TIMER2_COUNT_HIGH = 4'h9;
    localparam logic [3:0] REG_SERIAL_SHIFT = 4'ha;
    localparam logic [3:0] REG_AUX_CONTROL = 4'hb;
    localparam logic [3:0] REG_PERIPH_CONTROL = 4'hc;
    localparam logic [3:0] REG_INTR_FLAGS = 4'hd;
    localparam logic [3:0] REG_INTR_ENABLES = 4'he;
    localparam logic [3:0] REG_PORT_A_DATA_QUIET = 4'hf;

    // Reset value of every cleared 8-bit register
    localparam logic [7:0] REG_RESET = 8'h00;

    // aux_control fields
    localparam int AUX_LATCH_A = 0;
    localparam int AUX_LATCH_B = 1;
    localparam int AUX_TIMER_PIN = 7;

    // periph_control fields
    localparam int PCR_A_IN_RISE = 0;
    localparam int PCR_A_IO_MODE = 1;
    localparam int PCR_B_ONE_RISE = 4;
    localparam int PCR_B_TWO_MODE = 5;

    // Control line modes; bit 2 clear means input, bit 1 then picks the rising edge
    localparam int MODE_OUT_BIT = 2;
    localparam int MODE_RISE_BIT = 1;
    localparam logic [2:0] MODE_HANDSHAKE = 3'h4;
    localparam logic [2:0] MODE_PULSE = 3'h5;
    localparam logic [2:0] MODE_DRIVE_LOW = 3'h6;
    localparam logic [2:0] MODE_DRIVE_HIGH = 3'h7;

    // intr_flags / intr_enables bit positions
    localparam int FLAG_A_IO = 0;
    localparam int FLAG_A_IN = 1;
    localparam int FLAG_B_TWO = 3;
    localparam int FLAG_B_ONE = 4;
    localparam int FLAG_ANY = 7;
    localparam int IER_SET = 7;
    localparam int COUNT_PIN = 6;

    typedef struct packed {
        logic sel;
        logic rnw;
        logic [3:0] idx;
        logic [7:0] wdata;
    } ppac_req_t;

    typedef enum {HS_HIGH, HS_LOW, HS_PULSE} ppac_hs_t;

endpackage

// ### ppac_fifo.sv
module ppac_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic clear,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != CW'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (clear)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule

// ### ppac_core_monitor.sv
module ppac_core_monitor (
    // Clock and resets
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic chip_clear_n,
    // Host bus
    input wire logic select_high,
    input wire logic select_low_n,
    input wire logic read_not_write,
    input wire logic [3:0] reg_index,
    input wire logic [7:0] host_data_in,
    input wire logic host_data_oe,
    // Interrupt and pins
    input wire logic intr_req_out,
    input wire logic intr_req_oe,
    input wire logic [7:0] port_a_out,
    input wire logic [7:0] port_a_oe,
    input wire logic [7:0] port_b_oe,
    input wire logic a_ctl_io_out
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    wire logic rd = select_high && !select_low_n && read_not_write;
    wire logic wr = select_high && !select_low_n && !read_not_write && chip_clear_n;
    logic [2:0] io_mode;
    // Shadow of the a_ctl_io mode, as periph_control is not visible here
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || !chip_clear_n)
            io_mode <= 3'h0;
        else if (wr && reg_index == 4'hc)
            io_mode <= host_data_in[3:1];
    end
    sequence s_read_a;
        rd && reg_index == 4'h1;
    endsequence
    sequence s_low_pulse;
        !a_ctl_io_out ##1 a_ctl_io_out;
    endsequence
    chk_read_drive: assert property (rd |=> host_data_oe) else $error("bus idle after read");
    chk_bus_release: assert property (!rd |=> !host_data_oe) else $error("bus driven unasked");
    chk_clear_inputs:
        assert property (!chip_clear_n |=> port_a_oe == 8'h00 && port_b_oe == 8'h00) else $error("pins not inputs");
    chk_irq_drain: assert property (intr_req_out == 1'b0) else $error("irq line driven high");
    chk_dir_a_write:
        assert property (wr && reg_index == 4'h3 |=> port_a_oe == $past(host_data_in)) else $error("dir_a lost");
    chk_latch_a_write:
        assert property (wr && (reg_index == 4'h1 || reg_index == 4'hf) |=> port_a_out == $past(host_data_in))
        else $error("out_latch_a lost");
    chk_pulse_form:
        assert property (s_read_a ##0 io_mode == 3'h5 |=> s_low_pulse) else $error("no data-taken pulse");
    chk_quiet_read:
        assert property (rd && reg_index == 4'hf && a_ctl_io_out |=> a_ctl_io_out) else $error("quiet read shook");
    chk_irq_release:
        assert property (wr && reg_index == 4'he && host_data_in == 8'h7f |-> ##[1:2] !intr_req_oe)
        else $error("irq held");
endmodule

bind ppac_core ppac_core_monitor u_mon (.*);

// ### ppac_periph.sv
module ppac_periph (
    // System
    input wire logic clk,
    // Bench command
    input wire logic go,
    input wire logic [1:0] words,
    // Port A side
    input wire logic taken_n,
    output logic [7:0] pa,
    output logic ready
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        pa = 8'h00;
        ready = 1'b0;
        forever
        begin
            @(posedge clk iff go);
            for (int k = 0; k < words; k++)
            begin
                tk(1);
                pa = 8'h50 + 8'(k);
                tk(2);
                ready = 1'b1;
                // Hold time over: the word is no longer shown
                tk(6);
                pa = ~pa;
                for (int w = 0; w < 60 && taken_n; w++)
                    tk(1);
                tk(1);
                ready = 1'b0;
            end
        end
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
endmodule

// ### ppac_core_tb_top.sv
module ppac_core_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic chip_clear_n = 1'b1;
    logic select_high = 1'b0;
    logic select_low_n = 1'b1;
    logic read_not_write = 1'b1;
    logic b_one = 1'b0;
    logic go = 1'b0;
    logic [1:0] words = 2'h1;
    logic [3:0] reg_index = 4'h0;
    logic [7:0] wd = 8'h00, pb_drv = 8'h96, load = 8'hff, rdata;
    int fail_count = 0, n_tests = 0;
    wire logic [7:0] host_data_out, port_a_out, port_a_oe, port_b_out, port_b_oe, pa;
    wire logic host_data_oe, intr_req_out, intr_req_oe, a_ctl_in, a_ctl_io_out, a_ctl_io_oe, cp;
    // Pin levels: the enabled driver wins, load lets a pin read back other than driven
    wire logic [7:0] bus = host_data_oe ? host_data_out : wd;
    wire logic [7:0] port_a_in = ((port_a_oe & port_a_out) | (~port_a_oe & pa)) & load;
    wire logic [7:0] port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & pb_drv);
    wire logic a_ctl_io_in = a_ctl_io_oe ? a_ctl_io_out : 1'b1;
    ppac_core u_dut (.ref_clk, .rst_n, .chip_clear_n, .select_high, .select_low_n, .read_not_write, .reg_index,
        .host_data_in(bus), .host_data_out, .host_data_oe, .intr_req_out, .intr_req_oe, .port_a_in, .port_a_out,
        .port_a_oe, .a_latch_room(), .a_ctl_in, .a_ctl_io_in, .a_ctl_io_out, .a_ctl_io_oe, .port_b_in, .port_b_out,
        .port_b_oe, .b_ctl_one_in(b_one), .b_ctl_one_out(), .b_ctl_one_oe(), .b_ctl_two_in(1'b1),
        .b_ctl_two_out(), .b_ctl_two_oe(), .timer1_wave(1'b0), .count_pulse(cp));
    ppac_periph u_periph (.clk(ref_clk), .go, .words, .taken_n(a_ctl_io_in), .pa, .ready(a_ctl_in));
    always #12.5 ref_clk = ~ref_clk;
    task automatic tk(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One access, selected for exactly one cycle; read data is caught the cycle after
    task automatic acc(input logic rd, input logic [3:0] idx, input logic [7:0] d);
        tk(1);
        {select_high, select_low_n, read_not_write, reg_index, wd} = {2'b10, rd, idx, d};
        tk(1);
        {select_high, select_low_n, wd} = {2'b01, ~d};
        rdata = host_data_out;
    endtask
    task automatic rc(input logic [3:0] idx, input logic [7:0] exp);
        acc(1'b1, idx, 8'h00);
        cmp(rdata, exp);
    endtask
    task automatic start(input logic [1:0] n);
        words = n;
        go = 1'b1;
        tk(1);
        go = 1'b0;
    endtask
    task automatic t_reset();
        for (int i = 2; i < 15; i++)
            rc(4'(i), (i == 14) ? 8'h80 : 8'h00);
    endtask
    task automatic t_ports();
        acc(1'b0, 4'h1, 8'ha5);
        cmp(port_a_oe, 8'h00);
        acc(1'b0, 4'h3, 8'hff);
        cmp(port_a_out, 8'ha5);
        load = 8'hfe;
        rc(4'h1, 8'ha4);
        load = 8'hff;
        acc(1'b0, 4'h3, 8'h00);
        acc(1'b0, 4'h0, 8'h3c);
        acc(1'b0, 4'h2, 8'h0f);
        cmp(port_b_out, 8'h3c);
        rc(4'h0, 8'h9c);
        acc(1'b0, 4'hb, 8'h02);
        acc(1'b0, 4'hc, 8'h10);
        pb_drv = 8'h5a;
        b_one = 1'b1;
        tk(3);
        pb_drv = 8'ha5;
        tk(1);
        cmp(8'(cp), 8'h01);
        rc(4'h0, 8'h5c);
        acc(1'b0, 4'hb, 8'h00);
        rc(4'h0, 8'hac);
    endtask
    task automatic t_latch_a();
        acc(1'b0, 4'hb, 8'h01);
        acc(1'b0, 4'hc, 8'h09);
        start(2'h3);
        for (int k = 0; k < 3; k++)
        begin
            rdata = 8'h00;
            for (int w = 0; w < 40 && rdata[1] !== 1'b1; w++)
                acc(1'b1, 4'hd, 8'h00);
            tk(8);
            cmp(8'(a_ctl_io_out), 8'h01);
            rc(4'h1, 8'h50 + 8'(k));
            cmp(8'(a_ctl_io_out), 8'h00);
        end
        tk(30);
        rc(4'h1, 8'had);
    endtask
    task automatic t_irq();
        acc(1'b0, 4'hc, 8'h0b);
        acc(1'b0, 4'he, 8'h82);
        start(2'h1);
        for (int w = 0; w < 20 && intr_req_oe !== 1'b1; w++)
            tk(1);
        cmp(8'(intr_req_oe), 8'h01);
        acc(1'b1, 4'hd, 8'h00);
        cmp(rdata & 8'h82, 8'h82);
        acc(1'b0, 4'he, 8'h7f);
        tk(1);
        cmp(8'(intr_req_oe), 8'h00);
        acc(1'b0, 4'he, 8'h82);
        acc(1'b1, 4'hf, 8'h00);
        cmp(8'(intr_req_oe), 8'h01);
        acc(1'b1, 4'h1, 8'h00);
        cmp(8'({intr_req_oe, a_ctl_io_out}), 8'h00);
        tk(1);
        cmp(8'(a_ctl_io_out), 8'h01);
    endtask
    task automatic t_clear();
        acc(1'b0, 4'ha, 8'h77);
        acc(1'b0, 4'h2, 8'hff);
        chip_clear_n = 1'b0;
        tk(1);
        chip_clear_n = 1'b1;
        cmp(port_b_oe, 8'h00);
        rc(4'h2, 8'h00);
        rc(4'ha, 8'h77);
        rc(4'he, 8'h80);
    endtask
    task automatic summarize();
        if (fail_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        tk(2);
        rst_n = 1'b1;
        t_reset();
        t_ports();
        t_latch_a();
        t_irq();
        t_clear();
        summarize();
    end
    initial
    begin
        repeat (4000) @(posedge ref_clk);
        fail_count++;
        summarize();
    end
endmodule
